// ### core/edac_ctl_pkg.sv
/*
 * Constants for the controller that drives a clockless 32-bit EDAC chip.
 * Assumes a 100 MHz ref_clk; times are in ns and converted to cycles here.
 */
`default_nettype none
package edac_ctl_pkg;
  localparam int DATA_W = 32;
  localparam int CHECK_W = 7;
  localparam int CLK_NS = 10;
  // Check word valid after data is applied (longest time, so the wait covers it)
  localparam int CHECK_VALID_NS = 48;
  localparam int CHECK_VALID_CYC = (CHECK_VALID_NS + CLK_NS - 1) / CLK_NS;
  // Setup before the correct edge, hold after it, correction time
  localparam int SETUP_NS = 10;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS = 15;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CORRECT_NS = 58;
  localparam int CORRECT_CYC = (CORRECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // Mode select encodings {high, low}
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_READ = 2'h2;
  localparam logic [1:0] MODE_CORRECT = 2'h3;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_wr_gen = 3'b001,
    st_rd_setup = 3'b010,
    st_rd_hold = 3'b011,
    st_rd_out = 3'b100
  } state_t;
endpackage
`default_nettype wire

// ### core/edac_pins_if.sv
/*
 * Pin bundle between the controller sequencer and its pin synchroniser.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface edac_pins_if;
  logic [31:0] data_raw;
  logic [6:0] check_raw;
  logic single_raw_n;
  logic multi_raw_n;
  logic [31:0] data_sync;
  logic [6:0] check_sync;
  logic single_sync_n;
  logic multi_sync_n;
  modport sync (input data_raw, check_raw, single_raw_n, multi_raw_n,
                output data_sync, check_sync, single_sync_n, multi_sync_n);
  modport ctl (output data_raw, check_raw, single_raw_n, multi_raw_n,
               input data_sync, check_sync, single_sync_n, multi_sync_n);
endinterface
`default_nettype wire

// ### core/edac_pin_sync.sv
/*
 * Two-flop synchroniser for every pin the EDAC chip drives back.
 * Assumes pins are asynchronous to ref_clk.
 */
`default_nettype none
module edac_pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Pins
  edac_pins_if.sync pins
);
  logic [40:0] stage1;
  logic [40:0] stage2;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1 <= {2'h3, 39'h0};
      stage2 <= {2'h3, 39'h0};
    end else begin
      stage1 <= {pins.single_raw_n, pins.multi_raw_n, pins.check_raw, pins.data_raw};
      stage2 <= stage1;
    end
  end
  assign pins.single_sync_n = stage2[40];
  assign pins.multi_sync_n = stage2[39];
  assign pins.check_sync = stage2[38:32];
  assign pins.data_sync = stage2[31:0];
endmodule
`default_nettype wire

// ### core/edac_ctl.sv
/*
 * Controller that sequences a clockless 32-bit EDAC chip through write and
 * read-flag-correct cycles from a simple request/answer port.
 * Assumes the chip is wired to the pin ports and that pins are asynchronous.
 */
`default_nettype none
// Contract
// - Controller selects write mode with both mode selects low.
// - In write, data drive enables high before data word applied.
// - In write, check drive enable low so chip outputs check word.
// - Controller runs correction on every read regardless of flags.
// - Read mode is low select low, high select high.
module edac_ctl
  import edac_ctl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // User request
  input wire logic wr_req,
  input wire logic rd_req,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [CHECK_W-1:0] rd_check,
  input wire logic [DATA_W-1:0] rd_word,
  output logic busy,
  // User answer
  output logic done,
  output logic [DATA_W-1:0] out_data,
  output logic [CHECK_W-1:0] out_check,
  output logic single_err,
  output logic multi_err,
  // Chip mode pins
  output logic mode_select_low,
  output logic mode_select_high,
  output logic word_drive_enable_n,
  output logic check_drive_enable_n,
  // Chip data bus
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Chip check bus
  input wire logic [CHECK_W-1:0] check_in,
  output logic [CHECK_W-1:0] check_out,
  output logic check_oe,
  // Chip flags
  input wire logic single_fault_flag_n,
  input wire logic multi_fault_flag_n
);
  state_t state;
  state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic count_zero;
  logic take_wr;
  logic take_rd;

  edac_pins_if pins ();
  assign pins.data_raw = data_in;
  assign pins.check_raw = check_in;
  assign pins.single_raw_n = single_fault_flag_n;
  assign pins.multi_raw_n = multi_fault_flag_n;

  edac_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pins(pins)
  );

  function automatic logic [CNT_W-1:0] cyc(input int n);
    // Load value so the wait lasts n cycles, never under one
    cyc = (n < 1) ? CNT_W'(0) : CNT_W'(n - 1);
  endfunction

  // ************************************************
  // Sequencer
  // ************************************************
  assign count_zero = (count == '0);
  assign take_wr = (state == st_idle) && wr_req;
  assign take_rd = (state == st_idle) && rd_req && !wr_req;
  assign busy = (state != st_idle);
  assign mode_select_low = mode[0];
  assign mode_select_high = mode[1];

  always_comb begin
    next_state = state;
    next_count = count_zero ? count : count - CNT_W'(1);
    next_mode = mode;
    case (state)
      st_idle: begin
        if (take_wr) begin
          next_state = st_wr_gen;
          next_mode = MODE_WRITE;
          // Two extra cycles cover the flag/check synchroniser
          next_count = cyc(CHECK_VALID_CYC + 2);
        end else if (take_rd) begin
          next_state = st_rd_setup;
          next_mode = MODE_READ;
          next_count = cyc(SETUP_CYC + 2);
        end
      end
      st_wr_gen: begin
        if (count_zero) begin
          next_state = st_idle;
        end
      end
      st_rd_setup: begin
        if (count_zero) begin
          next_state = st_rd_hold;
          next_mode = MODE_CORRECT;
          next_count = cyc(HOLD_CYC);
        end
      end
      st_rd_hold: begin
        if (count_zero) begin
          next_state = st_rd_out;
          next_count = cyc(CORRECT_CYC + 2);
        end
      end
      st_rd_out: begin
        if (count_zero) begin
          next_state = st_idle;
          next_mode = MODE_READ;
        end
      end
      default: begin
        next_state = st_idle;
        next_mode = MODE_READ;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= st_idle;
      count <= '0;
      mode <= MODE_READ;
    end else begin
      state <= next_state;
      count <= next_count;
      mode <= next_mode;
    end
  end

  // ************************************************
  // Pin drive
  // ************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      data_out <= '0;
      data_oe <= 1'b0;
      check_out <= '0;
      check_oe <= 1'b0;
      word_drive_enable_n <= 1'b1;
      check_drive_enable_n <= 1'b1;
    end else begin
      // Chip word driver enabled in the same edge our data is released
      word_drive_enable_n <= !(next_state == st_rd_out);
      check_drive_enable_n <= !(next_state == st_wr_gen);
      data_oe <= (next_state == st_wr_gen) || (next_state == st_rd_setup)
        || (next_state == st_rd_hold);
      check_oe <= (next_state == st_rd_setup) || (next_state == st_rd_hold);
      if (take_wr) begin
        data_out <= wr_data;
      end else if (take_rd) begin
        data_out <= rd_word;
        check_out <= rd_check;
      end
    end
  end

  // ************************************************
  // Answer capture
  // ************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      done <= 1'b0;
      out_data <= '0;
      out_check <= '0;
      single_err <= 1'b0;
      multi_err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state == st_wr_gen && count_zero) begin
        done <= 1'b1;
        out_check <= pins.check_sync;
      end
      // Flags sampled while still in read mode, before correction
      if (state == st_rd_setup && count_zero) begin
        single_err <= !pins.single_sync_n;
        multi_err <= !pins.multi_sync_n;
      end
      if (state == st_rd_out && count_zero) begin
        done <= 1'b1;
        out_data <= pins.data_sync;
      end
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  write_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == st_wr_gen |-> mode == MODE_WRITE && data_oe && word_drive_enable_n)
    else $error("write mode pins wrong");
  write_oe_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == st_wr_gen |-> word_drive_enable_n && !check_drive_enable_n)
    else $error("write enables wrong");
  check_bus_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !check_drive_enable_n |-> !check_oe)
    else $error("check bus contention");
  write_wait_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    take_wr |=> (state == st_wr_gen) [*7])
    else $error("check wait too short");
  read_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == st_rd_setup |-> mode == MODE_READ && data_oe && check_oe)
    else $error("read mode pins wrong");
  correct_edge_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(mode_select_low) |-> $past(mode) == MODE_READ && mode_select_high)
    else $error("correct edge not from read");
  always_correct_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    take_rd |-> ##[1:8] mode == MODE_CORRECT)
    else $error("read without correction");
  bus_turn_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !word_drive_enable_n |-> !data_oe)
    else $error("data bus contention");
  cover_write_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    take_wr ##[1:10] done);
  cover_read_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    take_rd ##[1:20] done);
  cover_single_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    $rose(single_err) && !multi_err);
endmodule
`default_nettype wire

// ### verif/edac_chip_model.sv
/*
 * Behavioural model of the clockless EDAC chip and its two shared buses.
 * Assumes the controller drives its bus halves only while its enables are high.
 */
`default_nettype none
module edac_chip_model #(
  parameter int GEN_NS = 40,
  parameter int FLAG_NS = 5,
  parameter int FIX_NS = 50
) (
  // Mode and drive enables
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic word_drive_enable_n,
  input wire logic check_drive_enable_n,
  // Controller side of the buses
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic [6:0] check_out,
  input wire logic check_oe,
  // Resolved buses and flags
  output logic [31:0] data_in,
  output logic [6:0] check_in,
  output logic single_fault_flag_n,
  output logic multi_fault_flag_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] dlat, fx, fixed, dlast = 32'h0;
  logic [6:0] clat, syn, gen, cdrv, clast = 7'h00;
  // ****
  // Code: each data bit owns a distinct weight-3 column
  // ****
  function automatic logic [6:0] col(input int j);
    int n;
    n = 0;
    for (int v = 0; v < 128; v++) begin
      if ($countones(v[6:0]) == 3) begin
        if (n == j) return v[6:0];
        n = n + 1;
      end
    end
    return 7'h00;
  endfunction
  function automatic logic [6:0] chk(input logic [31:0] w);
    chk = 7'h00;
    for (int j = 0; j < 32; j++) begin
      if (w[j]) chk = chk ^ col(j);
    end
  endfunction
  // ****
  // Buses
  // ****
  // No pull-ups: a released bus shows the inverse of its last value
  always @* begin
    if (data_oe) dlast = data_out;
    else if (!word_drive_enable_n) dlast = fixed;
  end
  assign data_in = data_oe ? data_out : (!word_drive_enable_n ? fixed : ~dlast);
  assign cdrv = mode_select_high ? syn : gen;
  always @* begin
    if (check_oe) clast = check_out;
    else if (!check_drive_enable_n) clast = cdrv;
  end
  assign check_in = check_oe ? check_out : (!check_drive_enable_n ? cdrv : ~clast);
  assign #(GEN_NS) gen = chk(data_in);
  // ****
  // Flag and correct
  // ****
  always_latch begin
    if (!mode_select_low) begin
      dlat <= data_in;
      clat <= check_in;
    end
  end
  assign syn = chk(dlat) ^ clat;
  assign #(FLAG_NS) single_fault_flag_n = (syn == 7'h00);
  assign #(FLAG_NS) multi_fault_flag_n = (syn == 7'h00) || ^syn;
  always_comb begin
    fx = dlat;
    for (int j = 0; j < 32; j++) begin
      if (col(j) == syn) fx[j] = !dlat[j];
    end
  end
  assign #(FIX_NS) fixed = fx;
endmodule
`default_nettype wire

// ### verif/testbench.sv
/*
 * Self-checking bench: controller against the chip model, write and read runs.
 * Assumes the chip model resolves both shared buses.
 */
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench
  import edac_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rstn = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
  logic [DATA_W-1:0] wr_data = 32'h0, rd_word = 32'h0, out_data, data_in, data_out;
  logic [CHECK_W-1:0] rd_check = 7'h00, out_check, check_in, check_out;
  logic busy, done, single_err, multi_err, data_oe, check_oe, saw_wr, saw_corr, clash;
  logic mode_select_low, mode_select_high, word_drive_enable_n, check_drive_enable_n;
  logic single_fault_flag_n, multi_fault_flag_n;
  int n_fail = 0, tests_run = 0;
  logic [31:0] wl [4] = '{32'h0, 32'hffffffff, 32'ha5a55a5a, 32'h80000001};
  // Error kinds: none, bit 0, bit 31, check bit 3, double
  logic [31:0] dflip [5] = '{32'h0, 32'h1, 32'h80000000, 32'h0, 32'h00020020};
  logic [6:0] cflip [5] = '{7'h00, 7'h00, 7'h00, 7'h08, 7'h00};
  edac_ctl dut (.ref_clk, .rstn, .wr_req, .rd_req, .wr_data, .rd_check, .rd_word, .busy,
    .done, .out_data, .out_check, .single_err, .multi_err, .mode_select_low,
    .mode_select_high, .word_drive_enable_n, .check_drive_enable_n, .data_in, .data_out,
    .data_oe, .check_in, .check_out, .check_oe, .single_fault_flag_n, .multi_fault_flag_n);
  edac_chip_model chip (.mode_select_low, .mode_select_high, .word_drive_enable_n,
    .check_drive_enable_n, .data_out, .data_oe, .check_out, .check_oe, .data_in,
    .check_in, .single_fault_flag_n, .multi_fault_flag_n);
  // ****
  // Tasks
  // ****
  task automatic close_out();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Entered at a falling edge; watches the pins every cycle until done
  task automatic op(input logic wr, input logic [31:0] w, input logic [6:0] c);
    int i;
    wr_req = wr;
    rd_req = !wr;
    wr_data = w;
    rd_word = w;
    rd_check = c;
    saw_wr = 1'b0;
    saw_corr = 1'b0;
    clash = 1'b0;
    @(negedge ref_clk);
    wr_req = 1'b0;
    rd_req = 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++) begin
      @(negedge ref_clk);
      if ({mode_select_high, mode_select_low, word_drive_enable_n, check_drive_enable_n}
          === 4'h2) saw_wr = 1'b1;
      if (mode_select_high && mode_select_low) saw_corr = 1'b1;
      if ((data_oe && !word_drive_enable_n) || (check_oe && !check_drive_enable_n))
        clash = 1'b1;
    end
    if (i == 40) begin
      n_fail++;
      close_out();
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    `CHK({mode_select_high, mode_select_low, word_drive_enable_n, check_drive_enable_n, data_oe, check_oe, busy}, 7'h58)
    foreach (wl[k]) begin
      op(1'b1, wl[k], 7'h00);
      `CHK(out_check, chip.chk(wl[k]))
      `CHK({saw_wr, clash}, 2'h2)
    end
    $display("write test done");
    foreach (wl[k]) begin
      for (int e = 0; e < 5; e++) begin
        op(1'b0, wl[k] ^ dflip[e], chip.chk(wl[k]) ^ cflip[e]);
        if (e != 4) `CHK(out_data, wl[k])
        `CHK(single_err, e != 0)
        `CHK(multi_err, e == 4)
        `CHK({saw_corr, clash}, 2'h2)
      end
    end
    $display("read test done");
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire
